// File: core/analog_input_diag_regs.v
// Register bank for per-channel analog input diagnostics
//
// Operation
// - Auto mode: arm bit enables channel open detection
// - Manual mode: arm bit raises amplifier common mode
// - Sticky open flags, write one clears
// - Range arm bit enables over/undervoltage check
// - Sticky overvoltage flags, write one clears
// - Sticky undervoltage flags, write one clears
// - Pair selectors: even 5:3, odd 2:0, 7:6 zero
// - Selector codes pick pin or internal sources
// - Diagnostic source forces the ten volt range
// - Reset loads zero into every register
// - Queue one is manual, any other count automatic
`timescale 1ns/10ps
`default_nettype none
`include "diag_regs_defs.vh"

module analog_input_diag_regs (
  input  wire                   clock_i,
  input  wire                   reset_i,
  input  wire                   reg_wr_i,
  input  wire                   reg_rd_i,
  input  wire [`ADDR_W-1:0]     reg_addr_i,
  input  wire [`DATA_W-1:0]     reg_wdata_i,
  input  wire [`QUEUE_W-1:0]    open_queue_count_i,
  input  wire [`CHAN_N-1:0]     open_event_i,
  input  wire [`CHAN_N-1:0]     high_event_i,
  input  wire [`CHAN_N-1:0]     low_event_i,
  output reg  [`DATA_W-1:0]     reg_rdata_o,
  output reg                    reg_rvalid_o,
  output reg  [`CHAN_N-1:0]     open_detect_arm_o,
  output reg  [`CHAN_N-1:0]     common_mode_high_o,
  output reg  [`CHAN_N-1:0]     range_check_arm_o,
  output reg  [`CHAN_N-1:0]     wide_range_force_o,
  output reg  [`SEL_W-1:0]      chan1_source_o,
  output reg  [`SEL_W-1:0]      chan2_source_o,
  output reg  [`SEL_W-1:0]      chan3_source_o,
  output reg  [`SEL_W-1:0]      chan4_source_o,
  output wire [`CHAN_N-1:0]     open_flags_o,
  output wire [`CHAN_N-1:0]     high_flags_o,
  output wire [`CHAN_N-1:0]     low_flags_o
);

  reg  [`DATA_W-1:0]  open_arm_reg;
  reg  [`DATA_W-1:0]  range_arm_reg;
  reg  [`DATA_W-1:0]  pair_a_sel_reg;
  reg  [`DATA_W-1:0]  pair_b_sel_reg;
  reg  [`DATA_W-1:0]  rdata_next;
  wire                manual_mode;
  wire                wr_open_flags;
  wire                wr_high_flags;
  wire                wr_low_flags;
  wire [`CHAN_N-1:0]  open_auto_arm;
  wire [`SEL_W-1:0]   sel1;
  wire [`SEL_W-1:0]   sel2;
  wire [`SEL_W-1:0]   sel3;
  wire [`SEL_W-1:0]   sel4;

  // Queue count of one selects manual mode
  assign manual_mode = (open_queue_count_i == `QUEUE_MANUAL);

  assign wr_open_flags = reg_wr_i && (reg_addr_i == `ADDR_OPEN_FLAGS);
  assign wr_high_flags = reg_wr_i && (reg_addr_i == `ADDR_HIGH_FLAGS);
  assign wr_low_flags  = reg_wr_i && (reg_addr_i == `ADDR_LOW_FLAGS);

  // Open detection acts only in automatic mode
  assign open_auto_arm = manual_mode ? {`CHAN_N{1'b0}} : open_arm_reg;

  // Control registers
  always @(posedge clock_i) begin
    if (reset_i) begin
      open_arm_reg   <= `RESET_VALUE;
      range_arm_reg  <= `RESET_VALUE;
      pair_a_sel_reg <= `RESET_VALUE;
      pair_b_sel_reg <= `RESET_VALUE;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `ADDR_OPEN_ARM:   open_arm_reg   <= reg_wdata_i;
        `ADDR_RANGE_ARM:  range_arm_reg  <= reg_wdata_i;
        `ADDR_PAIR_A_SEL: pair_a_sel_reg <= reg_wdata_i & `PAIR_SEL_MASK;
        `ADDR_PAIR_B_SEL: pair_b_sel_reg <= reg_wdata_i & `PAIR_SEL_MASK;
        default: begin
        end
      endcase
    end
  end

  // Sticky fault flag banks
  sticky_flags u_open_flags (
    .clock_i      (clock_i),
    .reset_i      (reset_i),
    .arm_i        (open_auto_arm),
    .event_i      (open_event_i),
    .clear_we_i   (wr_open_flags),
    .clear_data_i (reg_wdata_i),
    .flags_o      (open_flags_o)
  );

  sticky_flags u_high_flags (
    .clock_i      (clock_i),
    .reset_i      (reset_i),
    .arm_i        (range_arm_reg),
    .event_i      (high_event_i),
    .clear_we_i   (wr_high_flags),
    .clear_data_i (reg_wdata_i),
    .flags_o      (high_flags_o)
  );

  sticky_flags u_low_flags (
    .clock_i      (clock_i),
    .reset_i      (reset_i),
    .arm_i        (range_arm_reg),
    .event_i      (low_event_i),
    .clear_we_i   (wr_low_flags),
    .clear_data_i (reg_wdata_i),
    .flags_o      (low_flags_o)
  );

  // Selector fields
  assign sel1 = pair_a_sel_reg[`ODD_SEL_LSB +: `SEL_W];
  assign sel2 = pair_a_sel_reg[`EVEN_SEL_LSB +: `SEL_W];
  assign sel3 = pair_b_sel_reg[`ODD_SEL_LSB +: `SEL_W];
  assign sel4 = pair_b_sel_reg[`EVEN_SEL_LSB +: `SEL_W];

  // Read mux, reserved and unmapped read zero
  always @* begin
    case (reg_addr_i)
      `ADDR_OPEN_ARM:   rdata_next = open_arm_reg;
      `ADDR_OPEN_FLAGS: rdata_next = open_flags_o;
      `ADDR_RANGE_ARM:  rdata_next = range_arm_reg;
      `ADDR_HIGH_FLAGS: rdata_next = high_flags_o;
      `ADDR_LOW_FLAGS:  rdata_next = low_flags_o;
      `ADDR_PAIR_A_SEL: rdata_next = pair_a_sel_reg;
      `ADDR_PAIR_B_SEL: rdata_next = pair_b_sel_reg;
      default:          rdata_next = `RESET_VALUE;
    endcase
  end

  // Registered outputs
  always @(posedge clock_i) begin
    if (reset_i) begin
      reg_rdata_o        <= `RESET_VALUE;
      reg_rvalid_o       <= 1'b0;
      open_detect_arm_o  <= `RESET_VALUE;
      common_mode_high_o <= `RESET_VALUE;
      range_check_arm_o  <= `RESET_VALUE;
      wide_range_force_o <= `RESET_VALUE;
      chan1_source_o     <= `SRC_INPUT_PIN;
      chan2_source_o     <= `SRC_INPUT_PIN;
      chan3_source_o     <= `SRC_INPUT_PIN;
      chan4_source_o     <= `SRC_INPUT_PIN;
    end else begin
      reg_rdata_o        <= reg_rd_i ? rdata_next : `RESET_VALUE;
      reg_rvalid_o       <= reg_rd_i;
      open_detect_arm_o  <= open_auto_arm;
      common_mode_high_o <= manual_mode ? open_arm_reg : `RESET_VALUE;
      range_check_arm_o  <= range_arm_reg;
      // Any code other than the input pin picks an internal source
      wide_range_force_o <= {{(`CHAN_N-4){1'b0}},
                             (sel4 != `SRC_INPUT_PIN),
                             (sel3 != `SRC_INPUT_PIN),
                             (sel2 != `SRC_INPUT_PIN),
                             (sel1 != `SRC_INPUT_PIN)};
      chan1_source_o     <= sel1;
      chan2_source_o     <= sel2;
      chan3_source_o     <= sel3;
      chan4_source_o     <= sel4;
    end
  end

endmodule // analog_input_diag_regs

`default_nettype wire

// File: common/diag_regs_defs.vh
// Constants for the analog input diagnostic register bank
`ifndef DIAG_REGS_DEFS_VH
`define DIAG_REGS_DEFS_VH

`define ADDR_W              7
`define DATA_W              8
`define CHAN_N              8
`define SEL_W               3

`define ADDR_OPEN_ARM       7'h23
`define ADDR_OPEN_FLAGS     7'h24
`define ADDR_RANGE_ARM      7'h25
`define ADDR_HIGH_FLAGS     7'h26
`define ADDR_LOW_FLAGS      7'h27
`define ADDR_PAIR_A_SEL     7'h28
`define ADDR_PAIR_B_SEL     7'h29

`define RESET_VALUE         8'h00
`define PAIR_SEL_MASK       8'h3f
`define ODD_SEL_LSB         0
`define EVEN_SEL_LSB        3

`define SRC_INPUT_PIN       3'h0
`define SRC_DIE_TEMP        3'h1
`define SRC_REF_SCALED      3'h2
`define SRC_ANALOG_REG      3'h3
`define SRC_DIGITAL_REG     3'h4
`define SRC_IFACE_SUPPLY    3'h5
`define SRC_ANALOG_GND      3'h6
`define SRC_ANALOG_SUPPLY   3'h7

`define QUEUE_MANUAL        9'h001
`define QUEUE_W             9

`endif

// File: core/sticky_flags.v
// Eight sticky fault flags with write-one-to-clear
`timescale 1ns/10ps
`default_nettype none
`include "diag_regs_defs.vh"

module sticky_flags (
  input  wire                 clock_i,
  input  wire                 reset_i,
  input  wire [`CHAN_N-1:0]   arm_i,
  input  wire [`CHAN_N-1:0]   event_i,
  input  wire                 clear_we_i,
  input  wire [`CHAN_N-1:0]   clear_data_i,
  output reg  [`CHAN_N-1:0]   flags_o
);

  wire [`CHAN_N-1:0] set_w;
  wire [`CHAN_N-1:0] clr_w;

  // Only armed channels set a flag
  assign set_w = arm_i & event_i;
  assign clr_w = clear_we_i ? clear_data_i : {`CHAN_N{1'b0}};

  always @(posedge clock_i) begin
    if (reset_i) begin
      flags_o <= `RESET_VALUE;
    end else begin
      // Set wins over a clear in the same cycle; flag holds after the fault ends
      flags_o <= (flags_o & ~clr_w) | set_w;
    end
  end

endmodule // sticky_flags

`default_nettype wire

// File: verif/analog_input_diag_regs_props.sv
// Assertion checker for the diagnostic register bank
`timescale 1ns/10ps
`default_nettype none
module analog_input_diag_regs_chk (
  input wire logic       clock_i,
  input wire logic       reset_i,
  input wire logic       reg_wr_i,
  input wire logic [8:0] open_queue_count_i,
  input wire logic [7:0] high_event_i,
  input wire logic [7:0] low_event_i,
  input wire logic [7:0] open_detect_arm_o,
  input wire logic [7:0] common_mode_high_o,
  input wire logic [7:0] wide_range_force_o,
  input wire logic [7:0] high_flags_o,
  input wire logic [7:0] low_flags_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  chk_mode_excl: assert property ((open_detect_arm_o & common_mode_high_o) == 8'h00)
    else $error("open arm and common mode both high");
  chk_manual_mode: assert property ((open_queue_count_i == 9'h001) [*3] |-> open_detect_arm_o == 8'h00)
    else $error("open arm high in manual mode");
  chk_auto_mode: assert property ((open_queue_count_i > 9'h001) [*3] |-> common_mode_high_o == 8'h00)
    else $error("common mode high in automatic mode");
  chk_high_hold: assert property (!reg_wr_i |=> (~high_flags_o & $past(high_flags_o)) == 8'h00)
    else $error("high flag dropped without a write");
  chk_low_hold: assert property (!reg_wr_i |=> (~low_flags_o & $past(low_flags_o)) == 8'h00)
    else $error("low flag dropped without a write");
  chk_high_cause: assert property (high_event_i == 8'h00 |=> (high_flags_o & ~$past(high_flags_o)) == 8'h00)
    else $error("high flag set with no event");
  chk_low_cause: assert property (low_event_i == 8'h00 |=> (low_flags_o & ~$past(low_flags_o)) == 8'h00)
    else $error("low flag set with no event");
  chk_wide_upper: assert property (wide_range_force_o[7:4] == 4'h0)
    else $error("range force on unmapped channel");
endmodule // analog_input_diag_regs_chk
bind analog_input_diag_regs analog_input_diag_regs_chk chk (.*);
`default_nettype wire

// File: verif/analog_fault_model.sv
// Analog fault source that pulses every channel's fault lines
`timescale 1ns/10ps
`default_nettype none
module analog_fault_model (
  input  wire logic       clock_i,
  input  wire logic       fire_i,
  output var  logic [7:0] fault_o
);
  initial fault_o = 8'h00;
  always @(posedge clock_i) fault_o <= {8{fire_i}};
endmodule // analog_fault_model
`default_nettype wire

// File: verif/analog_input_diag_regs_bench.sv
// Self-checking testbench for the diagnostic register bank
`timescale 1ns/10ps
`default_nettype none
module analog_input_diag_regs_bench;
  logic       clock_i = 0, reset_i = 1, wr = 0, rd = 0, fire = 0, rvalid;
  logic [6:0] addr = 7'h00;
  logic [7:0] wdata = 8'h00, rdata, oarm, cmh, rarm, wide, ev, of, hf, lf;
  logic [8:0] queue = 9'h100;
  logic [2:0] s1, s2, s3, s4;
  int         err_count = 0, tests_run = 0;
  always #2.5 clock_i = ~clock_i;
  analog_fault_model fm (.clock_i(clock_i), .fire_i(fire), .fault_o(ev));
  analog_input_diag_regs uut (.clock_i(clock_i), .reset_i(reset_i), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .open_queue_count_i(queue),
    .open_event_i(ev), .high_event_i(ev), .low_event_i(ev), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .open_detect_arm_o(oarm), .common_mode_high_o(cmh),
    .range_check_arm_o(rarm), .wide_range_force_o(wide), .chan1_source_o(s1),
    .chan2_source_o(s2), .chan3_source_o(s3), .chan4_source_o(s4),
    .open_flags_o(of), .high_flags_o(hf), .low_flags_o(lf));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    @(posedge clock_i) {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge clock_i) wr <= 0;
    @(negedge clock_i);
  endtask
  task automatic rd_reg(input logic [6:0] a, input logic [7:0] e);
    @(posedge clock_i) {rd, addr} <= {1'b1, a};
    @(posedge clock_i) rd <= 0;
    @(negedge clock_i) chk(rdata & {8{rvalid}}, e);
    chk({7'h00, rvalid}, 8'h01);
  endtask
  task automatic summarize;
    if (err_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #20000;
    err_count++;
    summarize();
  end
  initial begin
    repeat (6) @(posedge clock_i);
    reset_i <= 0;
    for (int a = 'h23; a <= 'h2a; a++) rd_reg(a[6:0], 8'h00);
    wr_reg(7'h23, 8'ha5);
    rd_reg(7'h23, 8'ha5);
    chk(oarm, 8'ha5);
    @(posedge clock_i) queue <= 9'h001;
    repeat (4) @(negedge clock_i);
    chk(cmh, 8'ha5);
    chk(oarm, 8'h00);
    @(posedge clock_i) queue <= 9'h100;
    repeat (4) @(negedge clock_i);
    chk(oarm, 8'ha5);
    wr_reg(7'h25, 8'h0f);
    @(posedge clock_i) fire <= 1;
    @(posedge clock_i) fire <= 0;
    repeat (4) @(negedge clock_i);
    chk(rarm, 8'h0f);
    rd_reg(7'h26, 8'h0f);
    rd_reg(7'h27, 8'h0f);
    rd_reg(7'h24, 8'ha5);
    wr_reg(7'h26, 8'h01);
    rd_reg(7'h26, 8'h0e);
    wr_reg(7'h27, 8'h00);
    rd_reg(7'h27, 8'h0f);
    wr_reg(7'h24, 8'ha0);
    rd_reg(7'h24, 8'h05);
    wr_reg(7'h2a, 8'hff);
    rd_reg(7'h25, 8'h0f);
    for (int c = 0; c < 8; c++) begin
      wr_reg(7'h28, {2'h3, c[2:0], ~c[2:0]});
      wr_reg(7'h29, {2'h3, ~c[2:0], c[2:0]});
      rd_reg(7'h28, {2'h0, c[2:0], ~c[2:0]});
      rd_reg(7'h29, {2'h0, ~c[2:0], c[2:0]});
      chk({2'h0, s2, s1}, {2'h0, c[2:0], ~c[2:0]});
      chk({2'h0, s4, s3}, {2'h0, ~c[2:0], c[2:0]});
      chk(wide, {4'h0, |(~c[2:0]), |c[2:0], |c[2:0], |(~c[2:0])});
    end
    summarize();
  end
endmodule // analog_input_diag_regs_bench
`default_nettype wire
